// ==== bstp_pkg.sv ====
package bstp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // instruction register
  localparam int IR_WIDTH = 3;
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_SAMPLE = 3'h1;
  localparam logic [2:0] INS_IDCODE = 3'h2;
  localparam logic [2:0] INS_CLAMP = 3'h3;
  localparam logic [2:0] INS_HIGHZ = 3'h4;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  // fixed pattern loaded in the capture step of an instruction scan
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  // instruction in force after reset
  localparam logic [2:0] IR_RESET = INS_IDCODE;

  ////////////////////////////////////////////////////////////////////////////
  // identification word layout
  localparam int ID_WIDTH = 32;
  localparam int ID_VER_POS = 28;
  localparam int ID_PART_POS = 12;
  localparam int ID_MFR_POS = 1;
  localparam int ID_FIXED_POS = 0;
  localparam logic ID_FIXED_BIT = 1'h1;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic BYPASS_RESET = 1'h0;
  localparam logic TDO_RESET = 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  // test access port states, one-hot
  typedef enum logic [15:0] {
    ST_TLR   = 16'h0001,
    ST_RTI   = 16'h0002,
    ST_SELDR = 16'h0004,
    ST_CAPDR = 16'h0008,
    ST_SHDR  = 16'h0010,
    ST_EX1DR = 16'h0020,
    ST_PSDR  = 16'h0040,
    ST_EX2DR = 16'h0080,
    ST_UPDR  = 16'h0100,
    ST_SELIR = 16'h0200,
    ST_CAPIR = 16'h0400,
    ST_SHIR  = 16'h0800,
    ST_EX1IR = 16'h1000,
    ST_PSIR  = 16'h2000,
    ST_EX2IR = 16'h4000,
    ST_UPIR  = 16'h8000
  } bstp_state_t;

endpackage : bstp_pkg

// ==== bstp_chain_if.sv ====
// strobes and serial data between the port controller and the boundary cells
interface bstp_chain_if;
  logic capture;    // capture step, one-cycle pulse
  logic shift;      // shift step, one-cycle pulse
  logic update;     // update step, one-cycle pulse
  logic serialIn;   // scan data entering the chain
  logic serialOut;  // scan data leaving the chain
  logic observe;    // chain is the selected data register
  logic extestMode; // pins driven from update stage
  logic clampMode;  // pins driven from update stage, bypass selected
  logic highzMode;  // all pins released
  modport ctrl (output capture, shift, update, serialIn, observe, extestMode, clampMode,
    highzMode, input serialOut);
  modport cells (input capture, shift, update, serialIn, observe, extestMode, clampMode,
    highzMode, output serialOut);
endinterface : bstp_chain_if

// ==== bstp_cells.sv ====
module bstp_cells #(
  parameter int NUM_PINS = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // controller side
  bstp_chain_if.cells chain,
  // pad side
  input wire logic [NUM_PINS-1:0] padIn,
  output logic [NUM_PINS-1:0] padOut,
  output logic [NUM_PINS-1:0] padOe,
  // core side
  input wire logic [NUM_PINS-1:0] coreOut,
  input wire logic [NUM_PINS-1:0] coreOe,
  output logic [NUM_PINS-1:0] coreIn
);
  import bstp_pkg::*;

  logic [NUM_PINS-1:0] padMeta_r; // first synchroniser stage
  logic [NUM_PINS-1:0] padSync_r; // settled pad level
  logic [2*NUM_PINS-1:0] shift_r; // even index in cell, odd index out cell
  logic [NUM_PINS-1:0] upd_r;     // output cell update stage
  logic testDrive;                // pins owned by the update stage

  ////////////////////////////////////////////////////////////////////////////
  // pad input synchroniser
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      padMeta_r <= '0;
      padSync_r <= '0;
    end else if (ce) begin
      padMeta_r <= padIn;
      padSync_r <= padMeta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture and shift of the cell chain
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shift_r <= '0;
    end else if (ce && chain.observe) begin
      if (chain.capture) begin
        // in cells observe only, out cells capture what the core drives
        for (int i = 0; i < NUM_PINS; i++) begin
          shift_r[2*i] <= padSync_r[i];
          shift_r[2*i+1] <= coreOut[i];
        end
      end else if (chain.shift) begin
        shift_r <= {chain.serialIn, shift_r[2*NUM_PINS-1:1]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // update stage of the out cells
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      upd_r <= '0;
    end else if (ce && chain.observe && chain.update) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        upd_r[i] <= shift_r[2*i+1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad multiplexing: two cells per pin
  assign testDrive = chain.extestMode | chain.clampMode;
  always_comb begin
    if (chain.highzMode) begin
      padOut = coreOut;
      padOe = '0;
    end else if (testDrive) begin
      padOut = upd_r;
      padOe = '1;
    end else begin
      padOut = coreOut;
      padOe = coreOe;
    end
  end
  assign coreIn = padSync_r;
  assign chain.serialOut = shift_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_highz_release;
    @(posedge clk) disable iff (!reset_n)
    chain.highzMode |-> (padOe == '0);
  endproperty
  a_highz_release: assert property (p_highz_release)
    else $error("pins driven while released");

  property p_extest_drive;
    @(posedge clk) disable iff (!reset_n)
    (chain.extestMode && !chain.highzMode) |-> (padOe == '1 && padOut == upd_r);
  endproperty
  a_extest_drive: assert property (p_extest_drive)
    else $error("update stage not on pins");

  property p_cell_capture;
    @(posedge clk) disable iff (!reset_n)
    (ce && chain.observe && chain.capture) |=> (shift_r[1] == $past(coreOut[0])
      && shift_r[0] == $past(padSync_r[0]));
  endproperty
  a_cell_capture: assert property (p_cell_capture)
    else $error("cell pair capture wrong");

endmodule : bstp_cells

// ==== bstp_tap.sv ====
// Summary of operation
// - boundary scan logic with registers and controller
// - data enters on TDI, leaves on TDO
// - boundary, identification, bypass and instruction registers
// - decoded instruction selects test and register
// - decode EXTEST, SAMPLE, IDCODE, BYPASS, CLAMP, HIGHZ
// - identification holds version, part, maker, one
// - bypass is one flip-flop between TDI, TDO
// - each bidirectional pin has two cells
// - in cell observes, out cell also drives
// - sixteen-state controller, data and instruction branches
// - TMS sampled at each rising TCK edge
module bstp_tap #(
  parameter int NUM_PINS = 4,
  parameter logic [3:0] ID_VERSION = 4'h1,     // arbitrary value
  parameter logic [15:0] ID_PART = 16'h1234,   // arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h055    // arbitrary value
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // test port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdoOe,
  // pads
  input wire logic [NUM_PINS-1:0] padIn,
  output logic [NUM_PINS-1:0] padOut,
  output logic [NUM_PINS-1:0] padOe,
  // core
  input wire logic [NUM_PINS-1:0] coreOut,
  input wire logic [NUM_PINS-1:0] coreOe,
  output logic [NUM_PINS-1:0] coreIn
);
  import bstp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [2:0] pinMeta_r;           // first synchroniser stage: tck, tms, tdi
  logic [2:0] pinSync_r;           // second synchroniser stage
  logic tckPrev_r;                 // settled tck one cycle ago
  logic tckRise;                   // rising test clock edge seen
  logic tckFall;                   // falling test clock edge seen
  logic tmsS;                      // settled mode select
  logic tdiS;                      // settled scan input
  bstp_state_t state_r;            // controller state
  bstp_state_t state_nxt;          // controller next state
  logic [IR_WIDTH-1:0] irShift_r;  // instruction shift stage
  logic [IR_WIDTH-1:0] ir_r;       // instruction in force
  logic [ID_WIDTH-1:0] idShift_r;  // identification chain
  logic bypass_r;                  // single flip-flop bypass
  logic tdo_r;                     // scan output flip-flop
  logic selId;                     // identification chain selected
  logic selBoundary;               // boundary chain selected
  logic drOut;                     // serial out of selected data register
  logic [ID_WIDTH-1:0] idWord;     // identification value
  bstp_chain_if chain ();

  // true in either shift state
  function automatic logic isShift(input bstp_state_t s);
    return (s == ST_SHDR) || (s == ST_SHIR);
  endfunction : isShift

  ////////////////////////////////////////////////////////////////////////////
  // test pin synchronisers and edge finder
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
      tckPrev_r <= 1'h0;
    end else if (ce) begin
      pinMeta_r <= {tck, tms, tdi};
      pinSync_r <= pinMeta_r;
      tckPrev_r <= pinSync_r[2];
    end
  end
  assign tckRise = ce & pinSync_r[2] & ~tckPrev_r;
  assign tckFall = ce & ~pinSync_r[2] & tckPrev_r;
  assign tmsS = pinSync_r[1];
  assign tdiS = pinSync_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // controller next state
  always_comb begin
    case (state_r)
      ST_TLR: state_nxt = tmsS ? ST_TLR : ST_RTI;
      ST_RTI: state_nxt = tmsS ? ST_SELDR : ST_RTI;
      ST_SELDR: state_nxt = tmsS ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: state_nxt = tmsS ? ST_EX1DR : ST_SHDR;
      ST_SHDR: state_nxt = tmsS ? ST_EX1DR : ST_SHDR;
      ST_EX1DR: state_nxt = tmsS ? ST_UPDR : ST_PSDR;
      ST_PSDR: state_nxt = tmsS ? ST_EX2DR : ST_PSDR;
      ST_EX2DR: state_nxt = tmsS ? ST_UPDR : ST_SHDR;
      ST_UPDR: state_nxt = tmsS ? ST_SELDR : ST_RTI;
      ST_SELIR: state_nxt = tmsS ? ST_TLR : ST_CAPIR;
      ST_CAPIR: state_nxt = tmsS ? ST_EX1IR : ST_SHIR;
      ST_SHIR: state_nxt = tmsS ? ST_EX1IR : ST_SHIR;
      ST_EX1IR: state_nxt = tmsS ? ST_UPIR : ST_PSIR;
      ST_PSIR: state_nxt = tmsS ? ST_EX2IR : ST_PSIR;
      ST_EX2IR: state_nxt = tmsS ? ST_UPIR : ST_SHIR;
      ST_UPIR: state_nxt = tmsS ? ST_SELDR : ST_RTI;
      default: state_nxt = ST_TLR;
    endcase
  end

  // state register steps on each rising test clock edge only
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r <= ST_TLR;
    end else if (tckRise) begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction register and decode
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irShift_r <= IR_RESET;
      ir_r <= IR_RESET;
    end else if (ce && state_r == ST_TLR) begin
      ir_r <= IR_RESET;
    end else if (tckRise) begin
      case (state_r)
        ST_CAPIR: irShift_r <= IR_CAPTURE;
        ST_SHIR: irShift_r <= {tdiS, irShift_r[IR_WIDTH-1:1]};
        ST_UPIR: ir_r <= irShift_r;
        default: irShift_r <= irShift_r;
      endcase
    end
  end

  // unknown codes fall back to the bypass path
  assign selId = (ir_r == INS_IDCODE);
  assign selBoundary = (ir_r == INS_EXTEST) || (ir_r == INS_SAMPLE);
  assign chain.extestMode = (ir_r == INS_EXTEST);
  assign chain.clampMode = (ir_r == INS_CLAMP);
  assign chain.highzMode = (ir_r == INS_HIGHZ);

  ////////////////////////////////////////////////////////////////////////////
  // identification chain
  always_comb begin
    idWord = '0;
    idWord[ID_VER_POS +: 4] = ID_VERSION;
    idWord[ID_PART_POS +: 16] = ID_PART;
    idWord[ID_MFR_POS +: 11] = ID_MAKER;
    idWord[ID_FIXED_POS] = ID_FIXED_BIT;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      idShift_r <= '0;
    end else if (tckRise && selId) begin
      if (state_r == ST_CAPDR) begin
        idShift_r <= idWord;
      end else if (state_r == ST_SHDR) begin
        idShift_r <= {tdiS, idShift_r[ID_WIDTH-1:1]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bypass stage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bypass_r <= BYPASS_RESET;
    end else if (tckRise && !selId && !selBoundary) begin
      if (state_r == ST_CAPDR) begin
        bypass_r <= 1'h0;
      end else if (state_r == ST_SHDR) begin
        bypass_r <= tdiS;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boundary chain strobes
  assign chain.observe = selBoundary;
  assign chain.capture = tckRise && (state_r == ST_CAPDR);
  assign chain.shift = tckRise && (state_r == ST_SHDR);
  assign chain.update = tckRise && (state_r == ST_UPDR);
  assign chain.serialIn = tdiS;

  bstp_cells #(
    .NUM_PINS(NUM_PINS)
  ) u_cells (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .chain(chain.cells),
    .padIn(padIn),
    .padOut(padOut),
    .padOe(padOe),
    .coreOut(coreOut),
    .coreOe(coreOe),
    .coreIn(coreIn)
  );

  ////////////////////////////////////////////////////////////////////////////
  // scan output, moved on the falling test clock edge
  always_comb begin
    if (selId) begin
      drOut = idShift_r[0];
    end else if (selBoundary) begin
      drOut = chain.serialOut;
    end else begin
      drOut = bypass_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tdo_r <= TDO_RESET;
    end else if (tckFall) begin
      tdo_r <= (state_r == ST_SHIR) ? irShift_r[0] : drOut;
    end
  end
  assign tdo = tdo_r;
  assign tdoOe = isShift(state_r);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_onehot;
    @(posedge clk) disable iff (!reset_n)
    $onehot(state_r);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("controller state not one-hot");

  property p_leave_reset;
    @(posedge clk) disable iff (!reset_n)
    (tckRise && state_r == ST_TLR && !tmsS) |=> (state_r == ST_RTI);
  endproperty
  a_leave_reset: assert property (p_leave_reset)
    else $error("no idle after low mode select");

  property p_hold_state;
    @(posedge clk) disable iff (!reset_n)
    !tckRise |=> $stable(state_r);
  endproperty
  a_hold_state: assert property (p_hold_state)
    else $error("state moved without clock edge");

  property p_tdo_release;
    @(posedge clk) disable iff (!reset_n)
    (tckRise && isShift(state_r) && tmsS) |=> !tdoOe;
  endproperty
  a_tdo_release: assert property (p_tdo_release)
    else $error("scan output driven outside shift");

  property p_tdo_edge;
    @(posedge clk) disable iff (!reset_n)
    !$stable(tdo_r) |-> $past(tckFall);
  endproperty
  a_tdo_edge: assert property (p_tdo_edge)
    else $error("scan output moved off falling edge");

  property p_ir_capture;
    @(posedge clk) disable iff (!reset_n)
    (tckRise && state_r == ST_CAPIR) |=> (irShift_r == IR_CAPTURE);
  endproperty
  a_ir_capture: assert property (p_ir_capture)
    else $error("instruction capture pattern wrong");

  property p_ir_update;
    @(posedge clk) disable iff (!reset_n)
    (tckRise && state_r == ST_UPIR) |=> (ir_r == $past(irShift_r));
  endproperty
  a_ir_update: assert property (p_ir_update)
    else $error("instruction not taken at update");

  property p_reset_idcode;
    @(posedge clk) disable iff (!reset_n)
    (ce && state_r == ST_TLR) |=> (ir_r == IR_RESET);
  endproperty
  a_reset_idcode: assert property (p_reset_idcode)
    else $error("reset instruction not loaded");

  property p_id_capture;
    @(posedge clk) disable iff (!reset_n)
    (tckRise && selId && state_r == ST_CAPDR) |=> (idShift_r == idWord);
  endproperty
  a_id_capture: assert property (p_id_capture)
    else $error("identification word not captured");

  property p_bypass_path;
    @(posedge clk) disable iff (!reset_n)
    (tckRise && ir_r == INS_BYPASS && state_r == ST_SHDR) |=> (bypass_r == $past(tdiS));
  endproperty
  a_bypass_path: assert property (p_bypass_path)
    else $error("bypass stage did not take scan input");

endmodule : bstp_tap

// ==== bstp_tester.sv ====
// behavioural scan controller on the far side of the test port
module bstp_tester (
  // test port
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdoOe
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam time HALF = 200ns; // half of the 400 ns link clock
  logic lastOe; // drive enable seen at the last sample
  logic oeSeen; // drive enable held over every bit of the last shift
  // link clock stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one link clock: levels set while low, output taken mid high phase
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #HALF tck = 1'b1;
    #(HALF / 2) q = tdoOe ? tdo : ~tdo;
    lastOe = tdoOe;
    #(HALF / 2) tck = 1'b0;
  endtask : step
  // shift n bits, lsb first, leaving on the last one
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = '0;
    oeSeen = 1'b1;
    for (int k = 0; k < n; k++) begin
      step(k == n - 1, din[k], q);
      dout[k] = q;
      oeSeen = oeSeen & lastOe;
    end
  endtask : shift
  // full scan from idle back to idle, instruction branch when ir is set
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
    output logic [31:0] dout);
    logic q;
    step(1'b1, 1'b0, q); // towards data branch
    if (ir) begin
      step(1'b1, 1'b0, q); // on to instruction branch
    end
    step(1'b0, 1'b0, q); // capture
    step(1'b0, 1'b0, q); // into shift
    shift(n, din, dout);
    step(1'b1, 1'b0, q); // update
    step(1'b0, 1'b0, q); // idle
  endtask : scan
  // five ones reach reset from anywhere, then idle
  task automatic reset_tap();
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : reset_tap
endmodule : bstp_tester

// ==== bstp_tb.sv ====
// self-checking bench for the scan port
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import bstp_pkg::*;
  localparam int NP = 4;
  localparam logic [3:0] VER = 4'h3; // arbitrary value
  localparam logic [15:0] PART = 16'hA5C3; // arbitrary value
  localparam logic [10:0] MAKER = 11'h2B1; // arbitrary value
  localparam logic [31:0] PRE = 32'h96; // preload pattern for the cells
  // design signals
  logic clk, reset_n, ce, tck, tms, tdi, tdo, tdoOe;
  logic [NP-1:0] padIn, padOut, padOe, coreOut, coreOe, coreIn;
  logic [31:0] d; // data shifted out by the controller
  int n_errors = 0;
  int comparisons = 0;
  ////////////////////////////////////////////////////////////////////////////
  bstp_tap #(.NUM_PINS(NP), .ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER)) u_dut (
    .clk(clk), .reset_n(reset_n), .ce(ce), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoOe(tdoOe), .padIn(padIn), .padOut(padOut), .padOe(padOe), .coreOut(coreOut),
    .coreOe(coreOe), .coreIn(coreIn));
  bstp_tester u_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe));
  // 50 ns system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // load an instruction and check the fixed capture pattern
  task automatic load_ir(input logic [2:0] code);
    u_tester.scan(1'b1, IR_WIDTH, 32'(code), d);
    check("ir capture", 32'(d[2:0]), 32'(IR_CAPTURE));
    repeat (4) @(posedge clk);
    // keep test clock edges off the system clock edges
    #1;
  endtask : load_ir
  ////////////////////////////////////////////////////////////////////////////
  // after reset: port released, pins follow the core
  task automatic t_reset();
    check("tdo enable idle", 32'(tdoOe), 32'h0);
    check("pad out", 32'(padOut), 32'(coreOut));
    check("pad enable", 32'(padOe), 32'(coreOe));
    check("core in", 32'(coreIn), 32'(padIn));
  endtask : t_reset
  // identification word read right after reset
  task automatic t_ident();
    // controller sits in reset state: walk it to idle first
    u_tester.reset_tap();
    u_tester.scan(1'b0, ID_WIDTH, 32'h0, d);
    check("ident word", d, {VER, PART, MAKER, ID_FIXED_BIT});
    check("tdo enable shift", 32'(u_tester.oeSeen), 32'h1);
    check("tdo enable after", 32'(tdoOe), 32'h0);
  endtask : t_ident
  // one stage between tdi and tdo, for the code and an unused one
  task automatic t_bypass();
    for (int i = 0; i < 2; i++) begin
      load_ir(i == 0 ? INS_BYPASS : 3'h5);
      u_tester.scan(1'b0, 4, 32'hB, d);
      check("bypass path", 32'(d[3:0]), 32'h6);
    end
  endtask : t_bypass
  // input cells capture pads, preload the update stage
  task automatic t_sample();
    @(posedge clk);
    #1 padIn = 4'h9;
    load_ir(INS_SAMPLE);
    u_tester.scan(1'b0, 2 * NP, PRE, d);
    check("in cells", 32'({d[6], d[4], d[2], d[0]}), 32'h9);
    check("out cells", 32'({d[7], d[5], d[3], d[1]}), 32'hA);
    check("sample pads", 32'(padOut), 32'(coreOut));
  endtask : t_sample
  // external test, release and clamp modes
  task automatic t_modes();
    load_ir(INS_EXTEST);
    check("extest enable", 32'(padOe), 32'hF);
    check("extest drive", 32'(padOut), 32'({PRE[7], PRE[5], PRE[3], PRE[1]}));
    load_ir(INS_HIGHZ);
    check("highz enable", 32'(padOe), 32'h0);
    load_ir(INS_CLAMP);
    check("clamp enable", 32'(padOe), 32'hF);
    check("clamp drive", 32'(padOut), 32'({PRE[7], PRE[5], PRE[3], PRE[1]}));
    u_tester.scan(1'b0, 2, 32'h1, d);
    check("clamp bypass", 32'(d[1:0]), 32'h2);
  endtask : t_modes
  // explicit ident code, then a return through reset state
  task automatic t_tapreset();
    load_ir(INS_IDCODE);
    check("pads released", 32'(padOe), 32'(coreOe));
    u_tester.scan(1'b0, ID_WIDTH, 32'h0, d);
    check("ident code", d, {VER, PART, MAKER, ID_FIXED_BIT});
    load_ir(INS_BYPASS);
    // enable low: a full reset walk must leave the controller untouched
    ce = 1'b0;
    u_tester.reset_tap();
    @(posedge clk);
    #1 ce = 1'b1;
    u_tester.scan(1'b0, 4, 32'hB, d);
    check("frozen bypass", 32'(d[3:0]), 32'h6);
    u_tester.reset_tap();
    u_tester.scan(1'b0, ID_WIDTH, 32'h0, d);
    check("ident after reset", d, {VER, PART, MAKER, ID_FIXED_BIT});
  endtask : t_tapreset
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    padIn = 4'h6;
    coreOut = 4'hA;
    coreOe = 4'h5;
    repeat (10) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    t_reset();
    t_ident();
    t_bypass();
    t_sample();
    t_modes();
    t_tapreset();
    end_of_test();
  end
  // cut a hang short
  initial begin
    #1ms;
    n_errors++;
    end_of_test();
  end
endmodule : testbench
